/* File: include/acs_pkg.sv */
/*
 * Shared constants and types of the converter start/read control block.
 * Assumes a 50 MHz system clock and a 32-bit classic Wishbone register bus.
 */
package acs_pkg;

   // ****************************************************************
   // Clock and conversion timing
   // ****************************************************************
   localparam int unsigned CLK_MHZ       = 50;
   localparam int unsigned T_BIT_NS      = 600;   // Time spent on one bit decision
   localparam int unsigned BIT_CYCLES    = (T_BIT_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SYNC_LATENCY  = 2;

   // ****************************************************************
   // Result format
   // ****************************************************************
   localparam int unsigned RES_W         = 12;
   localparam int unsigned BYTE_W        = 8;
   localparam int unsigned NIB_W         = 4;
   localparam logic [3:0]  MSB_IDX       = 4'hB;
   localparam logic [3:0]  LAST_IDX_12   = 4'h0;
   localparam logic [3:0]  LAST_IDX_8    = 4'h4;
   localparam logic [11:0] OE_N_ALL_OFF  = 12'hFFF;
   localparam logic [11:0] OE_N_WORD     = 12'h000;
   localparam logic [11:0] OE_N_BYTE     = 12'hF00;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam int unsigned ADR_W         = 4;
   localparam logic [3:0]  ADR_CTRL      = 4'h0;
   localparam logic [3:0]  ADR_STATUS    = 4'h4;
   localparam logic [3:0]  ADR_RESULT    = 4'h8;
   localparam int unsigned CTRL_PIN_EN   = 0;
   localparam int unsigned CTRL_SW_GO    = 1;
   localparam int unsigned CTRL_SW_LEN8  = 2;
   localparam int unsigned ST_BUSY       = 0;
   localparam int unsigned ST_LEN8       = 1;
   localparam int unsigned ST_RES_VALID  = 2;
   localparam int unsigned RES_LEN8_BIT  = 12;
   localparam logic        PIN_EN_RST    = 1'b1;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_BIT  = 2'b01,
      ACS_PUSH = 2'b10,
      ACS_DONE = 2'b11
   } acs_state_e;

   typedef struct packed {
      logic ce;
      logic cs_n;
      logic rc;
      logic length_byte_select;
      logic width_sel;
   } acs_pins_s;

   typedef struct packed {
      logic             len8;
      logic [RES_W-1:0] code;
   } acs_result_s;

endpackage

/* File: hw/acs_sync.sv */
/*
 * Two-flop synchroniser for a bundle of asynchronous level inputs.
 * Assumes inputs are levels; only the second stage is visible outside.
 */
`timescale 1ns/100ps
module acs_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         nrst_in,
   input  wire logic         en_in,
   input  wire logic [W-1:0] d_in,
   output      logic [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } acs_sync_s;

   acs_sync_s r_reg;
   acs_sync_s r_next;

   if (W < 1) begin : g_bad_w
      $error("acs_sync: W must be at least 1");
   end

   always_comb begin
      r_next    = r_reg;
      r_next.s1 = d_in;
      r_next.s2 = r_reg.s1;
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         r_reg <= '0;
      end else if (en_in) begin
         r_reg <= r_next;
      end
   end

   assign q_out = r_reg.s2;
endmodule

/* File: hw/acs_buf2.sv */
/*
 * Small FIFO with valid/ready on both sides; two entries by default.
 * Assumes one clock; full and empty are exact, the writer is stalled when full.
 */
`timescale 1ns/100ps
module acs_buf2 #(
   parameter int unsigned W     = 13,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic         clk_in,
   input  wire logic         nrst_in,
   input  wire logic         en_in,
   input  wire logic         in_valid_in,
   input  wire logic [W-1:0] in_data_in,
   output      logic         in_ready_out,
   output      logic         out_valid_out,
   output      logic [W-1:0] out_data_out,
   input  wire logic         out_ready_in
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0]           wr_ptr;
      logic [PW-1:0]           rd_ptr;
      logic [CW-1:0]           count;
   } acs_buf_s;

   acs_buf_s r_reg;
   acs_buf_s r_next;
   logic     push;
   logic     pop;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("acs_buf2: DEPTH must be a power of two, at least 2");
   end

   assign in_ready_out  = (r_reg.count != CW'(DEPTH));
   assign out_valid_out = (r_reg.count != '0);
   assign out_data_out  = r_reg.mem[r_reg.rd_ptr];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   always_comb begin
      r_next = r_reg;
      if (push) begin
         r_next.mem[r_reg.wr_ptr] = in_data_in;
         r_next.wr_ptr            = r_reg.wr_ptr + PW'(1);
      end
      if (pop) begin
         r_next.rd_ptr = r_reg.rd_ptr + PW'(1);
      end
      r_next.count = r_reg.count + CW'(push) - CW'(pop);
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         r_reg <= '0;
      end else if (en_in) begin
         r_reg <= r_next;
      end
   end
endmodule

/* File: hw/acs_conv_ctrl.sv */
/*
 * Start/read control of a 12-bit successive approximation converter,
 * with a Wishbone register port and a two-entry result stream.
 * Assumes pins and comparator are asynchronous; bus is on CLK_IN.
 */
// Functional notes
// - Last control to reach start state triggers conversion
// - Simultaneous control changes accepted, same start delay
// - Busy high exactly during conversion
// - Data drivers off while converting
// - Control transitions during conversion do not restart it
// - Start transition while busy relatches length
// - Nothing happens unless enable high, select low; software starts need neither
// - Three start events: enable, select, read/convert
// - Length select one gives 8 bits, zero 12
// - Read/convert low converts, high reads
// - Word read drives all 12 bits
// - Byte read, length high: low nibble, four zeros
// - Only length latched; 8-bit leaves four LSBs zero
// - Busy falls after result latched on outputs; here busy falls on the edge that latches result, and DB_OUT loads it later
// - Outputs on only if read, idle, enabled, selected
`timescale 1ns/100ps
module acs_conv_ctrl #(
   parameter int unsigned CYCLES_PER_BIT = acs_pkg::BIT_CYCLES,
   parameter int unsigned BUF_DEPTH      = 2
) (
   input  wire logic        CLK_IN,
   input  wire logic        NRST_IN,
   input  wire logic        CLK_EN_IN,
   // Converter control pins
   input  wire logic        CE_IN,
   input  wire logic        CS_N_IN,
   input  wire logic        RC_IN,
   input  wire logic        LENGTH_BYTE_SELECT_IN,
   input  wire logic        WIDTH_SEL_IN,
   input  wire logic        COMP_IN,
   output      logic        BUSY_FLAG_OUT,
   output      logic        HOLD_OUT,
   output      logic [11:0] DAC_CODE_OUT,
   output      logic [11:0] DB_OUT,
   output      logic [11:0] DB_OE_N_OUT,
   // Wishbone slave
   input  wire logic        WB_CYC_IN,
   input  wire logic        WB_STB_IN,
   input  wire logic        WB_WE_IN,
   input  wire logic [3:0]  WB_ADR_IN,
   input  wire logic [3:0]  WB_SEL_IN,
   input  wire logic [31:0] WB_DAT_IN,
   output      logic [31:0] WB_DAT_OUT,
   output      logic        WB_ACK_OUT
);

   // ****************************************************************
   // Types and checks
   // ****************************************************************
   localparam int unsigned CNT_W = 8;

   typedef struct packed {
      acs_pkg::acs_state_e state;
      logic                start_lvl_q;
      logic                len8;
      logic [3:0]          bit_idx;
      logic [CNT_W-1:0]    cnt;
      logic [11:0]         trial;
      logic [11:0]         result;
      logic                res_len8;
      logic                busy;
      logic [11:0]         db;
      logic [11:0]         db_oe_n;
      logic                pin_en;
      logic                ack;
      logic [31:0]         dat;
   } acs_ctrl_s;

   // Drivers off and pin starts allowed out of reset
   localparam acs_ctrl_s RST_VAL = '{
      state:   acs_pkg::ACS_IDLE,
      db_oe_n: acs_pkg::OE_N_ALL_OFF,
      pin_en:  acs_pkg::PIN_EN_RST,
      default: '0
   };

   // Comparator needs its sync latency before the decision is taken
   if (CYCLES_PER_BIT < acs_pkg::SYNC_LATENCY + 1 || CYCLES_PER_BIT > 255) begin : g_bad_cpb
      $error("acs_conv_ctrl: CYCLES_PER_BIT out of range 3..255");
   end

   acs_ctrl_s          r_reg;
   acs_ctrl_s          r_next;
   acs_pkg::acs_pins_s pins_raw;
   acs_pkg::acs_pins_s pins;
   logic               comp_s;
   logic               buf_in_ready;
   logic               buf_out_valid;
   acs_pkg::acs_result_s buf_out_data;
   acs_pkg::acs_result_s buf_in_data;
   logic               buf_in_valid;
   logic               buf_pop;

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   assign pins_raw = '{ce: CE_IN, cs_n: CS_N_IN, rc: RC_IN,
                       length_byte_select: LENGTH_BYTE_SELECT_IN, width_sel: WIDTH_SEL_IN};

   acs_sync #(.W($bits(acs_pkg::acs_pins_s))) u_pin_sync (
      .clk_in  (CLK_IN),
      .nrst_in (NRST_IN),
      .en_in   (CLK_EN_IN),
      .d_in    (pins_raw),
      .q_out   (pins)
   );

   // Decision lags the trial code by the two sync stages
   acs_sync #(.W(1)) u_comp_sync (
      .clk_in  (CLK_IN),
      .nrst_in (NRST_IN),
      .en_in   (CLK_EN_IN),
      .d_in    (COMP_IN),
      .q_out   (comp_s)
   );

   // ****************************************************************
   // Result stream toward software
   // ****************************************************************
   assign buf_in_valid = (r_reg.state == acs_pkg::ACS_PUSH);
   assign buf_in_data  = '{len8: r_reg.len8, code: r_reg.trial};

   acs_buf2 #(.W($bits(acs_pkg::acs_result_s)), .DEPTH(BUF_DEPTH)) u_res_buf (
      .clk_in        (CLK_IN),
      .nrst_in       (NRST_IN),
      .en_in         (CLK_EN_IN),
      .in_valid_in   (buf_in_valid),
      .in_data_in    (buf_in_data),
      .in_ready_out  (buf_in_ready),
      .out_valid_out (buf_out_valid),
      .out_data_out  (buf_out_data),
      .out_ready_in  (buf_pop)
   );

   // ****************************************************************
   // Control logic
   // ****************************************************************
   logic bus_req;
   logic wr_ctrl;
   logic sw_go;
   logic start_lvl;
   logic start_evt;
   logic read_lvl;
   logic can_start;
   logic [3:0] last_idx;

   // Ack blocks a second take while the master still holds stb
   assign bus_req = WB_CYC_IN & WB_STB_IN & ~r_reg.ack;
   assign wr_ctrl = bus_req & WB_WE_IN & WB_SEL_IN[0] & (WB_ADR_IN == acs_pkg::ADR_CTRL);
   assign sw_go   = wr_ctrl & WB_DAT_IN[acs_pkg::CTRL_SW_GO];
   // Reading an empty buffer answers zero and pops nothing
   assign buf_pop = bus_req & ~WB_WE_IN & (WB_ADR_IN == acs_pkg::ADR_RESULT) & buf_out_valid;

   // ****************************************************************
   // Next state
   // ****************************************************************

   always_comb begin
      r_next    = r_reg;
      r_next.ack = 1'b0;

      // One level covering all three start edges; rises on whichever input is last
      start_lvl = r_reg.pin_en & pins.ce & ~pins.cs_n & ~pins.rc;
      start_evt = start_lvl & ~r_reg.start_lvl_q;
      r_next.start_lvl_q = start_lvl;
      // Done behaves as idle, so a start may follow at once
      can_start = (r_reg.state == acs_pkg::ACS_IDLE) || (r_reg.state == acs_pkg::ACS_DONE);
      // Read at every bit end, so a relatched length acts late
      last_idx  = r_reg.len8 ? acs_pkg::LAST_IDX_8 : acs_pkg::LAST_IDX_12;

      // Software register writes
      if (wr_ctrl) begin
         r_next.pin_en = WB_DAT_IN[acs_pkg::CTRL_PIN_EN];
      end

      unique case (r_reg.state)
         acs_pkg::ACS_IDLE, acs_pkg::ACS_DONE: begin
            r_next.state = acs_pkg::ACS_IDLE;
         end
         acs_pkg::ACS_BIT: begin
            r_next.cnt = r_reg.cnt + CNT_W'(1);
            if (r_reg.cnt == CNT_W'(CYCLES_PER_BIT - 1)) begin
               r_next.cnt = '0;
               // Comparator low: trial too high, drop the bit
               if (!comp_s) begin
                  r_next.trial[r_reg.bit_idx] = 1'b0;
               end
               // 8-bit stops early, so bits below never get set
               if (r_reg.bit_idx == last_idx) begin
                  r_next.state = acs_pkg::ACS_PUSH;
               end else begin
                  r_next.bit_idx = r_reg.bit_idx - 4'h1;
                  r_next.trial[r_reg.bit_idx - 4'h1] = 1'b1;
               end
            end
         end
         acs_pkg::ACS_PUSH: begin
            // Stalled here while the stream is full; busy stays high meanwhile
            if (buf_in_ready) begin
               r_next.result   = r_reg.trial;
               r_next.res_len8 = r_reg.len8;
               r_next.state    = acs_pkg::ACS_DONE;
            end
         end
      endcase

      // Starts from pins or software; while busy a pin start only relatches the length
      if (start_evt || sw_go) begin
         if (can_start) begin
            r_next.state   = acs_pkg::ACS_BIT;
            r_next.len8    = sw_go ? WB_DAT_IN[acs_pkg::CTRL_SW_LEN8]
                                   : pins.length_byte_select;
            r_next.bit_idx = acs_pkg::MSB_IDX;
            r_next.cnt     = '0;
            r_next.trial   = '0;
            r_next.trial[acs_pkg::MSB_IDX] = 1'b1;
         end else if (start_evt) begin
            r_next.len8 = pins.length_byte_select;
         end
      end

      // Busy only in the converting states; falls on the same edge the result is latched
      r_next.busy = (r_next.state == acs_pkg::ACS_BIT) ||
                    (r_next.state == acs_pkg::ACS_PUSH);

      // Data drivers
      read_lvl = pins.ce & ~pins.cs_n & pins.rc & ~r_reg.busy & ~r_next.busy;
      // Drivers follow the synced pins; off by default each cycle
      r_next.db_oe_n = acs_pkg::OE_N_ALL_OFF;
      if (read_lvl) begin
         if (pins.width_sel) begin
            r_next.db_oe_n = acs_pkg::OE_N_WORD;
            r_next.db      = r_reg.result;
         end else begin
            r_next.db_oe_n = acs_pkg::OE_N_BYTE;
            if (pins.length_byte_select) begin
               r_next.db = {4'h0, r_reg.result[acs_pkg::NIB_W-1:0], 4'h0};
            end else begin
               r_next.db = {4'h0, r_reg.result[acs_pkg::RES_W-1:acs_pkg::NIB_W]};
            end
         end
      end

      // Bus answers: one-cycle ack, unmapped reads give zero
      if (bus_req) begin
         r_next.ack = 1'b1;
         r_next.dat = '0;
         if (!WB_WE_IN) begin
            unique case (WB_ADR_IN)
               acs_pkg::ADR_CTRL: begin
                  r_next.dat[acs_pkg::CTRL_PIN_EN] = r_reg.pin_en;
               end
               acs_pkg::ADR_STATUS: begin
                  r_next.dat[acs_pkg::ST_BUSY]      = r_reg.busy;
                  r_next.dat[acs_pkg::ST_LEN8]      = r_reg.len8;
                  r_next.dat[acs_pkg::ST_RES_VALID] = buf_out_valid;
               end
               acs_pkg::ADR_RESULT: begin
                  if (buf_out_valid) begin
                     r_next.dat[acs_pkg::RES_W-1:0]       = buf_out_data.code;
                     r_next.dat[acs_pkg::RES_LEN8_BIT]    = buf_out_data.len8;
                  end
               end
               default: begin
                  r_next.dat = '0;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************

   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         r_reg <= RST_VAL;
      end else if (CLK_EN_IN) begin
         r_reg <= r_next;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign BUSY_FLAG_OUT = r_reg.busy;
   // Sample/hold stays in hold for exactly the busy time
   assign HOLD_OUT      = r_reg.busy;
   assign DAC_CODE_OUT  = r_reg.trial;
   assign DB_OUT        = r_reg.db;
   assign DB_OE_N_OUT   = r_reg.db_oe_n;
   assign WB_DAT_OUT    = r_reg.dat;
   assign WB_ACK_OUT    = r_reg.ack;
endmodule

/* File: tb/acs_comp_model.sv */
/*
 * Far-side model: ideal comparator between the held input level and the trial code.
 * Assumes the level is a 12-bit code held steady by the bench during a conversion.
 */
`timescale 1ns/100ps
module acs_comp_model (
   input  wire logic [11:0] dac_code_in,
   input  wire logic [11:0] level_in,
   output      logic        comp_out
);
   // Keep the trial bit when the input is at or above it
   assign comp_out = (level_in >= dac_code_in);
endmodule

/* File: tb/acs_conv_ctrl_props.sv */
/*
 * Concurrent checks on the top-level ports of the converter control block.
 * Assumes one clock domain; the bind below hands on the bit-time parameter.
 */
`timescale 1ns/100ps
module acs_conv_ctrl_chk #(
   parameter int unsigned CYCLES_PER_BIT = acs_pkg::BIT_CYCLES
) (
   input  wire logic        CLK_IN,
   input  wire logic        NRST_IN,
   input  wire logic        CLK_EN_IN,
   input  wire logic        CE_IN,
   input  wire logic        CS_N_IN,
   input  wire logic        RC_IN,
   input  wire logic        LENGTH_BYTE_SELECT_IN,
   input  wire logic        WIDTH_SEL_IN,
   input  wire logic        BUSY_FLAG_OUT,
   input  wire logic        HOLD_OUT,
   input  wire logic [11:0] DAC_CODE_OUT,
   input  wire logic [11:0] DB_OUT,
   input  wire logic [11:0] DB_OE_N_OUT,
   input  wire logic        WB_CYC_IN,
   input  wire logic        WB_STB_IN,
   input  wire logic        WB_ACK_OUT
);
   // ****************************************************************
   // Busy length counter
   // ****************************************************************
   int unsigned busy_cnt_reg;
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         busy_cnt_reg <= 0;
      end else if (CLK_EN_IN) begin
         busy_cnt_reg <= BUSY_FLAG_OUT ? busy_cnt_reg + 1 : 0;
      end
   end
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!NRST_IN);
   // ****************************************************************
   // Properties
   // ****************************************************************
   property p_oe_busy; BUSY_FLAG_OUT |-> DB_OE_N_OUT == 12'hFFF; endproperty
   a_oe_busy: assert property (p_oe_busy) else $error("outputs driven while busy");
   property p_hold; HOLD_OUT == BUSY_FLAG_OUT; endproperty
   a_hold: assert property (p_hold) else $error("hold differs from busy");
   property p_busy_len; $fell(BUSY_FLAG_OUT) |-> busy_cnt_reg >= 8 * CYCLES_PER_BIT + 1;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("conversion too short");
   property p_dac; $rose(BUSY_FLAG_OUT) |-> DAC_CODE_OUT == 12'h800; endproperty
   a_dac: assert property (p_dac) else $error("first trial code wrong");
   property p_start_src;
      $rose(BUSY_FLAG_OUT) |-> $past(CE_IN && !CS_N_IN && !RC_IN, 3)
         || $past(WB_CYC_IN, 1) || $past(WB_CYC_IN, 2);
   endproperty
   a_start_src: assert property (p_start_src) else $error("start without cause");
   property p_oe_sel; DB_OE_N_OUT != 12'hFFF |-> $past(CE_IN && !CS_N_IN && RC_IN, 3);
   endproperty
   a_oe_sel: assert property (p_oe_sel) else $error("outputs on without read");
   property p_word; DB_OE_N_OUT == 12'h000 |-> $past(WIDTH_SEL_IN, 3); endproperty
   a_word: assert property (p_word) else $error("word enable in byte mode");
   property p_low_byte;
      DB_OE_N_OUT == 12'hF00 && $past(LENGTH_BYTE_SELECT_IN, 3) |-> DB_OUT[3:0] == 4'h0;
   endproperty
   a_low_byte: assert property (p_low_byte) else $error("low byte tail not zero");
   property p_ack_pulse; WB_ACK_OUT |=> !WB_ACK_OUT; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
   property p_ack_cause; WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && CLK_EN_IN |=> WB_ACK_OUT;
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("request not acknowledged");
endmodule
bind acs_conv_ctrl acs_conv_ctrl_chk #(.CYCLES_PER_BIT(CYCLES_PER_BIT)) chk_u (
   .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .CLK_EN_IN(CLK_EN_IN), .CE_IN(CE_IN),
   .CS_N_IN(CS_N_IN), .RC_IN(RC_IN), .LENGTH_BYTE_SELECT_IN(LENGTH_BYTE_SELECT_IN),
   .WIDTH_SEL_IN(WIDTH_SEL_IN), .BUSY_FLAG_OUT(BUSY_FLAG_OUT), .HOLD_OUT(HOLD_OUT),
   .DAC_CODE_OUT(DAC_CODE_OUT), .DB_OUT(DB_OUT), .DB_OE_N_OUT(DB_OE_N_OUT),
   .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT)
);

/* File: tb/acs_conv_ctrl_bench.sv */
/*
 * Self-checking bench of the converter control block: pin starts, reads, bus, buffer.
 * Assumes the comparator model on the far side and a short bit time.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module acs_conv_ctrl_bench;
   localparam int CPB = 4;
   localparam int L12 = 12 * CPB + 1;
   localparam int L8  = 8 * CPB + 1;
   localparam int SD  = acs_pkg::SYNC_LATENCY + 2;   // Pin edge to busy seen here
   logic        clk, nrst, ce, cs_n, rc, lbs, wsel, comp, busy, hold, cyc, stb, we, ack;
   logic [11:0] dac, db, oe_n, lvl;
   logic [3:0]  adr, sel;
   logic [31:0] wdi, wdo, rd;
   int          fail_count, comparisons, len;
   acs_conv_ctrl #(.CYCLES_PER_BIT(CPB)) dut_u (
      .CLK_IN(clk), .NRST_IN(nrst), .CLK_EN_IN(1'b1), .CE_IN(ce), .CS_N_IN(cs_n),
      .RC_IN(rc), .LENGTH_BYTE_SELECT_IN(lbs), .WIDTH_SEL_IN(wsel), .COMP_IN(comp),
      .BUSY_FLAG_OUT(busy), .HOLD_OUT(hold), .DAC_CODE_OUT(dac), .DB_OUT(db),
      .DB_OE_N_OUT(oe_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
      .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdi), .WB_DAT_OUT(wdo), .WB_ACK_OUT(ack));
   acs_comp_model far_u (.dac_code_in(dac), .level_in(lvl), .comp_out(comp));
   // ****************************************************************
   // Drivers
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic pins(input logic c, input logic s, input logic r, input logic a,
                       input logic w);
      ce <= c; cs_n <= s; rc <= r; lbs <= a; wsel <= w;
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int t;
      t = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdi <= d;
      do begin @(posedge clk); t++; end while (ack !== 1'b1 && t < 50);
      rd = wdo;
      `CHK("ack", 1'b1, ack)
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_rise(input int d);
      int t;
      t = 0;
      while (busy !== 1'b1 && t < 20) begin @(posedge clk); t++; end
      `CHK("busy_rise", 1'b1, busy)
      `CHK("start_delay", d, t)
   endtask
   task automatic count(output int n);
      n = 0;
      while (busy === 1'b1 && n < 500) begin @(posedge clk); n++; end
   endtask
   task automatic conv(input int d, output int n);
      wait_rise(d);
      count(n);
   endtask
   task automatic rd_result(input logic [11:0] code, input logic l8);
      wb(1'b0, acs_pkg::ADR_RESULT, 32'h0);
      `CHK("result", {19'h0, l8, code}, rd)
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      `CHK("busy", 1'b0, busy)
      `CHK("oe_n", acs_pkg::OE_N_ALL_OFF, oe_n)
      wb(1'b0, acs_pkg::ADR_CTRL, 32'h0);
      `CHK("pin_en", acs_pkg::PIN_EN_RST, rd[acs_pkg::CTRL_PIN_EN])
      wb(1'b0, 4'hC, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      $display("test reset done");
   endtask
   task automatic t_pin_start();
      pins(0, 0, 0, 0, 1); tick(4);
      pins(1, 0, 0, 0, 1); conv(SD, len);
      `CHK("len12", L12, len)
      pins(1, 0, 1, 0, 1); tick(5);
      `CHK("word_oe", acs_pkg::OE_N_WORD, oe_n)
      `CHK("word", 12'hA5C, db)
      pins(1, 0, 1, 0, 0); tick(5);
      `CHK("byte_oe", acs_pkg::OE_N_BYTE, oe_n)
      `CHK("hi_byte", 12'h0A5, db)
      pins(1, 0, 1, 1, 0); tick(5);
      `CHK("lo_byte", 12'h0C0, db)
      pins(1, 1, 0, 1, 1); tick(5);
      `CHK("desel_oe", acs_pkg::OE_N_ALL_OFF, oe_n)
      pins(1, 0, 0, 1, 1); conv(SD, len);
      `CHK("len8", L8, len)
      pins(1, 0, 1, 1, 1); tick(5);
      `CHK("word8", 12'hA50, db)
      rd_result(12'hA5C, 1'b0);
      rd_result(12'hA50, 1'b1);
      $display("test pin_start done");
   endtask
   task automatic t_dyn_start();
      pins(0, 1, 1, 0, 1); tick(4);
      pins(1, 0, 0, 0, 1); wait_rise(SD);
      pins(0, 0, 0, 0, 1); tick(2);
      pins(1, 0, 0, 0, 1); tick(2);
      count(len);
      `CHK("len_ignored", L12, len + 4)
      pins(1, 0, 1, 0, 1); tick(4);
      pins(1, 0, 0, 0, 1); wait_rise(SD);
      pins(1, 0, 1, 1, 1); tick(2);
      pins(1, 0, 0, 1, 1); tick(2);
      count(len);
      `CHK("len_relatch", L8, len + 4)
      rd_result(12'hA5C, 1'b0);
      rd_result(12'hA50, 1'b1);
      $display("test dyn_start done");
   endtask
   task automatic t_no_op();
      pins(0, 1, 1, 0, 1); tick(4);
      pins(1, 1, 0, 0, 1); tick(2);
      pins(0, 1, 0, 0, 1); tick(2);
      pins(1, 1, 0, 0, 1); tick(6);
      `CHK("no_select", 1'b0, busy)
      wb(1'b1, acs_pkg::ADR_CTRL, 32'h0);
      pins(1, 0, 0, 0, 1); tick(8);
      `CHK("pin_disabled", 1'b0, busy)
      pins(0, 1, 1, 0, 1); tick(4);
      wb(1'b1, acs_pkg::ADR_CTRL, 32'h1);
      $display("test no_op done");
   endtask
   task automatic t_fifo();
      repeat (2) begin
         wb(1'b1, acs_pkg::ADR_CTRL, 32'h3);
         conv(0, len);
         // Busy rises at the ack edge; its first cycle passes inside the bus task
         `CHK("sw_len", L12, len + 1)
      end
      // Third result finds the buffer full and must wait
      wb(1'b1, acs_pkg::ADR_CTRL, 32'h3); wait_rise(0); tick(L12 + 8);
      `CHK("stall", 1'b1, busy)
      wb(1'b0, acs_pkg::ADR_STATUS, 32'h0);
      `CHK("st_nonempty", 1'b1, rd[acs_pkg::ST_RES_VALID])
      rd_result(12'hA5C, 1'b0);
      tick(4);
      `CHK("unstall", 1'b0, busy)
      repeat (2) rd_result(12'hA5C, 1'b0);
      wb(1'b0, acs_pkg::ADR_RESULT, 32'h0);
      `CHK("empty", 32'h0, rd)
      $display("test fifo done");
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      nrst = 1'b0; ce = 1'b0; cs_n = 1'b1; rc = 1'b1; lbs = 1'b0; wsel = 1'b1;
      lvl = 12'hA5C; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'hF;
      wdi = 32'h0; fail_count = 0; comparisons = 0;
      tick(8);
      nrst <= 1'b1;
      tick(1);
      t_reset(); t_pin_start(); t_dyn_start(); t_no_op(); t_fifo();
      finish_test();
   end
   initial begin
      #400000;
      fail_count++;
      $display("watchdog expired");
      finish_test();
   end
endmodule
